/* File: verilog/gar_regs.svh */
// flag addresses, protocol codes, reset values and timing counts
`ifndef GAR_REGS_SVH
`define GAR_REGS_SVH

// ----------------------------------------------------------------
// flag addresses (read-only input flags)
// ----------------------------------------------------------------
`define GAR_ADDR_RSVD_A      16'h0131
`define GAR_ADDR_RSVD_B      16'h0132
`define GAR_ADDR_WARN_EXC    16'h0133

// ----------------------------------------------------------------
// flag addresses (read/write output flags)
// ----------------------------------------------------------------
`define GAR_ADDR_SOUNDER     16'h0190
`define GAR_ADDR_TEST_DUE    16'h0191
`define GAR_ADDR_FAILSAFE    16'h0192
`define GAR_ADDR_WARN_EN     16'h0193
`define GAR_ADDR_WARN_RELAY  16'h0194

// ----------------------------------------------------------------
// function codes, coil values, exception codes
// ----------------------------------------------------------------
`define GAR_FC_READ_COILS    8'h01
`define GAR_FC_READ_INPUTS   8'h02
`define GAR_FC_WRITE_COIL    8'h05
`define GAR_COIL_ON          16'hFF00
`define GAR_COIL_OFF         16'h0000
`define GAR_EXC_FUNC         8'h01
`define GAR_EXC_ADDR         8'h02
`define GAR_EXC_VALUE        8'h03

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GAR_RST_FAILSAFE     1'h0
`define GAR_RST_WARN_EN      1'h0
`define GAR_RST_WARN_RELAY   1'h0
`define GAR_RST_SOUNDER      1'h0
`define GAR_RST_TEST_DUE     1'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define GAR_AGE_YEARS        64'd1
`define GAR_NS_PER_YEAR      64'd31536000000000000
`define GAR_CLK_PERIOD_NS    64'd10
`define GAR_AGE_CYCLES       (`GAR_AGE_YEARS * `GAR_NS_PER_YEAR / `GAR_CLK_PERIOD_NS)

`endif

/* File: verilog/gar_pkg.sv */
// types shared by the gas alarm relay flag block
package gar_pkg;

  typedef logic [15:0] gar_ppm_t;
  typedef logic [7:0]  gar_code_t;
  typedef logic [15:0] gar_addr_t;
  typedef logic [63:0] gar_count_t;

  // state of the flag bank and its answer port
  typedef struct packed {
    logic      rsp_valid;
    logic      rsp_data;
    logic      rsp_exc;
    gar_code_t rsp_exc_code;
    logic      warn_flag;
    logic      sounder;
    logic      test_due;
    logic      failsafe;
    logic      warn_en;
    logic      warn_relay;
    logic      relay;
  } gar_bank_s;

  // state of the sensor age timer
  typedef struct packed {
    gar_count_t count;
    logic       aged;
    logic       expire;
  } gar_age_s;

endpackage

/* File: verilog/gar_age_timer.sv */
// sensor age timer: flags once the sensor has run past its test age
`include "gar_regs.svh"

module gar_age_timer #(
  parameter gar_pkg::gar_count_t AGE_CYCLES = `GAR_AGE_CYCLES
) (
  input  wire logic clk_in,     // system clock
  input  wire logic rst_n_in,   // async reset, active low
  output logic      aged_out,   // level: age limit passed
  output logic      expire_out  // one-cycle pulse when age limit passes
);
  import gar_pkg::*;

  gar_age_s s_r;
  gar_age_s s_nxt;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // counter stops at the limit so it never wraps and re-fires
  always_comb begin
    s_nxt        = s_r;
    s_nxt.expire = 1'h0;
    if (!s_r.aged) begin
      if (s_r.count >= AGE_CYCLES) begin
        s_nxt.aged   = 1'h1;
        s_nxt.expire = 1'h1;
      end else begin
        s_nxt.count = s_r.count + 64'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign aged_out   = s_r.aged;
  assign expire_out = s_r.expire;

endmodule

/* File: verilog/gar_flag_bank.sv */
// status flags, output flags and relay decision of the gas detector
`include "gar_regs.svh"

module gar_flag_bank #(
  parameter gar_pkg::gar_count_t AGE_CYCLES = `GAR_AGE_CYCLES
) (
  input  wire logic              clk_in,                // system clock
  input  wire logic              rst_n_in,              // async reset, active low
  input  wire gar_pkg::gar_ppm_t gas_level_in,          // gas level, ppm
  input  wire gar_pkg::gar_ppm_t warn_threshold_in,     // warning threshold, ppm
  input  wire gar_pkg::gar_ppm_t alarm_threshold_in,    // alarm threshold, ppm
  input  wire logic              sensor_fault_in,       // sensor fault detected
  input  wire logic              req_valid_in,          // request strobe, one cycle
  input  wire gar_pkg::gar_code_t req_func_in,          // function code
  input  wire gar_pkg::gar_addr_t req_addr_in,          // flag address
  input  wire logic [15:0]       req_value_in,          // write coil value
  output logic                   rsp_valid_out,         // answer strobe, one cycle
  output logic                   rsp_data_out,          // flag value read or written
  output logic                   rsp_exc_out,           // answer is an exception
  output gar_pkg::gar_code_t     rsp_exc_code_out,      // exception code
  output logic                   relay_energised_out,   // relay coil drive
  output logic                   sounder_on_out,        // sounder flag
  output logic                   warn_exceeded_out,     // warning exceeded flag
  output logic                   test_due_out,          // sensor test due flag
  output logic                   failsafe_out           // failsafe polarity selected
);
  import gar_pkg::*;

  gar_bank_s s_r;
  gar_bank_s s_nxt;
  logic      aged_pulse;
  logic      relay_active;
  logic      warn_hit;
  logic      alarm_hit;
  logic      coil_bit;
  logic      coil_ok;

  // ----------------------------------------------------------------
  // sensor age
  // ----------------------------------------------------------------
  gar_age_timer #(
    .AGE_CYCLES (AGE_CYCLES)
  ) u_age (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .aged_out   (),
    .expire_out (aged_pulse)
  );

  // ----------------------------------------------------------------
  // threshold compares
  // ----------------------------------------------------------------
  // warning relay path honours the enable so a disabled warning
  // cannot trip the relay through a stale threshold
  always_comb begin
    warn_hit  = s_r.warn_en && (gas_level_in > warn_threshold_in);
    alarm_hit = gas_level_in > alarm_threshold_in;
    relay_active = sensor_fault_in
                 | alarm_hit
                 | (s_r.warn_relay & warn_hit);
  end

  // ----------------------------------------------------------------
  // coil value decode
  // ----------------------------------------------------------------
  always_comb begin
    coil_bit = 1'h0;
    coil_ok  = 1'h1;
    if (req_value_in == `GAR_COIL_ON) begin
      coil_bit = 1'h1;
    end else if (req_value_in != `GAR_COIL_OFF) begin
      coil_ok = 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt              = s_r;
    s_nxt.rsp_valid    = 1'h0;
    s_nxt.rsp_data     = 1'h0;
    s_nxt.rsp_exc      = 1'h0;
    s_nxt.rsp_exc_code = 8'h00;

    // warning flag tracks the gas only while enabled
    if (s_r.warn_en) begin
      s_nxt.warn_flag = gas_level_in >= warn_threshold_in;
    end else begin
      s_nxt.warn_flag = 1'h0;
    end

    if (req_valid_in) begin
      s_nxt.rsp_valid = 1'h1;
      case (req_func_in)
        `GAR_FC_READ_INPUTS: begin
          case (req_addr_in)
            `GAR_ADDR_RSVD_A:   s_nxt.rsp_data = 1'h0;
            `GAR_ADDR_RSVD_B:   s_nxt.rsp_data = 1'h0;
            `GAR_ADDR_WARN_EXC: s_nxt.rsp_data = s_r.warn_flag;
            default: begin
              s_nxt.rsp_exc      = 1'h1;
              s_nxt.rsp_exc_code = `GAR_EXC_ADDR;
            end
          endcase
        end
        `GAR_FC_READ_COILS: begin
          case (req_addr_in)
            `GAR_ADDR_SOUNDER:    s_nxt.rsp_data = s_r.sounder;
            `GAR_ADDR_TEST_DUE:   s_nxt.rsp_data = s_r.test_due;
            `GAR_ADDR_FAILSAFE:   s_nxt.rsp_data = s_r.failsafe;
            `GAR_ADDR_WARN_EN:    s_nxt.rsp_data = s_r.warn_en;
            `GAR_ADDR_WARN_RELAY: s_nxt.rsp_data = s_r.warn_relay;
            default: begin
              s_nxt.rsp_exc      = 1'h1;
              s_nxt.rsp_exc_code = `GAR_EXC_ADDR;
            end
          endcase
        end
        `GAR_FC_WRITE_COIL: begin
          if (!coil_ok) begin
            s_nxt.rsp_exc      = 1'h1;
            s_nxt.rsp_exc_code = `GAR_EXC_VALUE;
          end else begin
            s_nxt.rsp_data = coil_bit;
            case (req_addr_in)
              `GAR_ADDR_SOUNDER:    s_nxt.sounder    = coil_bit;
              // the test flag can be cleared, but not forced on early
              `GAR_ADDR_TEST_DUE:   s_nxt.test_due   = coil_bit & s_r.test_due;
              `GAR_ADDR_FAILSAFE:   s_nxt.failsafe   = coil_bit;
              `GAR_ADDR_WARN_EN:    s_nxt.warn_en    = coil_bit;
              `GAR_ADDR_WARN_RELAY: s_nxt.warn_relay = coil_bit;
              default: begin
                // input flags, reserved ones too, refuse writes
                s_nxt.rsp_data     = 1'h0;
                s_nxt.rsp_exc      = 1'h1;
                s_nxt.rsp_exc_code = `GAR_EXC_ADDR;
              end
            endcase
          end
        end
        default: begin
          s_nxt.rsp_exc      = 1'h1;
          s_nxt.rsp_exc_code = `GAR_EXC_FUNC;
        end
      endcase
    end

    // age expiry after the write so that a same-cycle clear loses
    if (aged_pulse) begin
      s_nxt.test_due = 1'h1;
    end

    // polarity: inactive state is energised in failsafe mode
    s_nxt.relay = relay_active ^ s_r.failsafe;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // relay resets de-energised; with failsafe at its reset value that
  // is the standard power-up state, so no strap needs catching
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r            <= '0;
      s_r.failsafe   <= `GAR_RST_FAILSAFE;
      s_r.warn_en    <= `GAR_RST_WARN_EN;
      s_r.warn_relay <= `GAR_RST_WARN_RELAY;
      s_r.sounder    <= `GAR_RST_SOUNDER;
      s_r.test_due   <= `GAR_RST_TEST_DUE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rsp_valid_out       = s_r.rsp_valid;
  assign rsp_data_out        = s_r.rsp_data;
  assign rsp_exc_out         = s_r.rsp_exc;
  assign rsp_exc_code_out    = s_r.rsp_exc_code;
  assign relay_energised_out = s_r.relay;
  assign sounder_on_out      = s_r.sounder;
  assign warn_exceeded_out   = s_r.warn_flag;
  assign test_due_out        = s_r.test_due;
  assign failsafe_out        = s_r.failsafe;

endmodule

/* File: sim/gar_flag_bank_asserts.sv */
// port assertions for the gas alarm relay flag bank
module gar_flag_bank_asserts #(
  parameter gar_pkg::gar_count_t AGE_CYCLES = 64'd20
) (
  input wire logic               clk_in,              // clock
  input wire logic               rst_n_in,            // reset
  input wire gar_pkg::gar_ppm_t  gas_level_in,        // gas
  input wire gar_pkg::gar_ppm_t  warn_threshold_in,   // warn level
  input wire gar_pkg::gar_ppm_t  alarm_threshold_in,  // alarm level
  input wire logic               sensor_fault_in,     // fault
  input wire logic               req_valid_in,        // request
  input wire gar_pkg::gar_code_t req_func_in,         // function
  input wire gar_pkg::gar_addr_t req_addr_in,         // address
  input wire logic [15:0]        req_value_in,        // value
  input wire logic               rsp_valid_out,       // answer
  input wire logic               rsp_data_out,        // data
  input wire logic               rsp_exc_out,         // exception
  input wire gar_pkg::gar_code_t rsp_exc_code_out,    // code
  input wire logic               relay_energised_out, // relay
  input wire logic               warn_exceeded_out,   // warning
  input wire logic               test_due_out,        // test due
  input wire logic               failsafe_out         // polarity
);
  timeunit 1ns;
  timeprecision 100ps;
  import gar_pkg::*;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // edges since reset release
  gar_count_t age_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) age_r <= 64'd0;
    else age_r <= age_r + 64'd1;
  end
  sequence s_rd_in(a);
    req_valid_in && req_func_in == 8'h02 && req_addr_in == a;
  endsequence
  sequence s_bad_fn;
    req_valid_in && !(req_func_in inside {8'h01, 8'h02, 8'h05});
  endsequence
  sequence s_fs_on;
    req_valid_in && req_func_in == 8'h05 && req_addr_in == 16'h0192 && req_value_in == 16'hFF00;
  endsequence
  a_rsp_follows: assert property (req_valid_in |=> rsp_valid_out)
    else $error("request not answered");
  a_rsp_cause: assert property (rsp_valid_out |-> $past(req_valid_in))
    else $error("answer without request");
  a_exc_clean: assert property (rsp_exc_out |-> rsp_valid_out && !rsp_data_out)
    else $error("exception carries data");
  a_bad_func: assert property (s_bad_fn |=> rsp_exc_out && rsp_exc_code_out == 8'h01)
    else $error("bad function accepted");
  a_rsvd_zero: assert property (s_rd_in(16'h0131) or s_rd_in(16'h0132)
    |=> !rsp_exc_out && !rsp_data_out) else $error("reserved flag not zero");
  a_warn_read: assert property (s_rd_in(16'h0133)
    |=> rsp_data_out == $past(warn_exceeded_out)) else $error("warning read wrong");
  a_warn_cmp: assert property (warn_exceeded_out |-> $past(gas_level_in >= warn_threshold_in))
    else $error("warning flag without cause");
  a_fs_write: assert property (s_fs_on |=> failsafe_out && rsp_data_out)
    else $error("failsafe write lost");
  a_relay_act: assert property ($past(rst_n_in) && $past(sensor_fault_in ||
    gas_level_in > alarm_threshold_in) |-> relay_energised_out == !$past(failsafe_out))
    else $error("relay not active");
  a_relay_idle: assert property ($past(rst_n_in) && !$past(sensor_fault_in ||
    gas_level_in > warn_threshold_in || gas_level_in > alarm_threshold_in)
    |-> relay_energised_out == $past(failsafe_out)) else $error("relay not idle");
  a_test_age: assert property (test_due_out |-> age_r >= AGE_CYCLES)
    else $error("test flag too early");
endmodule

bind gar_flag_bank gar_flag_bank_asserts #(.AGE_CYCLES(AGE_CYCLES)) u_chk (.*);

/* File: sim/gar_master_model.sv */
// supervisor-side master model issuing single flag requests
module gar_master_model (
  input  wire logic               clk_in,    // clock
  output gar_pkg::gar_code_t      func_out,  // function
  output gar_pkg::gar_addr_t      addr_out,  // address
  output logic [15:0]             value_out, // value
  output logic                    valid_out, // strobe
  input  wire logic               valid_in,  // answer
  input  wire logic               data_in,   // data
  input  wire logic               exc_in,    // exception
  input  wire gar_pkg::gar_code_t code_in    // code
);
  timeunit 1ns;
  timeprecision 100ps;
  import gar_pkg::*;
  initial begin
    valid_out = 1'b0;
    {func_out, addr_out, value_out} = 40'hA5_5A5A_0F0F;
  end
  // answer is taken one falling edge later
  task automatic xfer(input gar_code_t f, input gar_addr_t a, input logic [15:0] v,
                      output logic ok, e, d, output gar_code_t c);
    @(negedge clk_in);
    {valid_out, func_out, addr_out, value_out} = {1'b1, f, a, v};
    @(negedge clk_in);
    {ok, e, d, c} = {valid_in, exc_in, data_in, code_in};
    valid_out = 1'b0;
    // released lines must not keep looking like the last request
    {func_out, addr_out, value_out} = ~{func_out, addr_out, value_out};
  endtask
endmodule

/* File: sim/gar_flag_bank_bench.sv */
// self-checking bench for the gas alarm relay flag bank
module gar_flag_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import gar_pkg::*;
  // short age so the test flag rises within the run
  localparam gar_count_t AGE = 64'd20;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, sensor_fault_in = 1'b0;
  gar_ppm_t    gas_level_in = 16'h0000, warn_threshold_in = 16'h0064;
  gar_ppm_t    alarm_threshold_in = 16'h00C8;
  logic        req_valid_in, rsp_valid_out, rsp_data_out, rsp_exc_out;
  logic        relay_energised_out, sounder_on_out, warn_exceeded_out, test_due_out;
  logic        failsafe_out;
  gar_code_t   req_func_in, rsp_exc_code_out;
  gar_addr_t   req_addr_in;
  logic [15:0] req_value_in;
  int          error_cnt = 0, checks_done = 0, cyc = 0;
  gar_flag_bank #(.AGE_CYCLES(AGE)) DUT (.*);
  gar_master_model mst (.clk_in(clk_in), .func_out(req_func_in), .addr_out(req_addr_in),
    .value_out(req_value_in), .valid_out(req_valid_in), .valid_in(rsp_valid_out),
    .data_in(rsp_data_out), .exc_in(rsp_exc_out), .code_in(rsp_exc_code_out));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      results();
    end
  end
  task automatic results;
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tx(input gar_code_t f, input gar_addr_t a, input logic [15:0] v,
                    input gar_code_t ec, input logic ed);
    logic ok, e, d;
    gar_code_t c;
    mst.xfer(f, a, v, ok, e, d, c);
    chk(ok, 1'b1);
    chk(e, ec != 8'h00);
    chk(c, ec);
    chk(d, ed);
  endtask
  task automatic settle(input gar_ppm_t g, input logic f);
    @(negedge clk_in);
    gas_level_in = g;
    sensor_fault_in = f;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic t_reset;
    chk(relay_energised_out, 1'b0);
    chk(failsafe_out, 1'b0);
    for (int i = 0; i < 5; i++) if (i != 1) tx(8'h01, 16'h0190 + 16'(i), 0, 0, 0);
  endtask
  task automatic t_age;
    chk(test_due_out, 1'b0);
    repeat (AGE + 4) @(negedge clk_in);
    chk(test_due_out, 1'b1);
    tx(8'h01, 16'h0191, 16'h0000, 8'h00, 1'b1);
    tx(8'h05, 16'h0191, 16'h0000, 8'h00, 1'b0);
    chk(test_due_out, 1'b0);
  endtask
  task automatic t_warn;
    settle(16'h0064, 1'b0);
    chk(warn_exceeded_out, 1'b0);
    tx(8'h05, 16'h0193, 16'hFF00, 8'h00, 1'b1);
    settle(16'h0064, 1'b0);
    chk(warn_exceeded_out, 1'b1);
    tx(8'h02, 16'h0133, 16'h0000, 8'h00, 1'b1);
    tx(8'h05, 16'h0133, 16'hFF00, 8'h02, 1'b0);
    settle(16'h0063, 1'b0);
    chk(warn_exceeded_out, 1'b0);
    tx(8'h05, 16'h0193, 16'h0000, 8'h00, 1'b0);
    settle(16'h0096, 1'b0);
    chk(warn_exceeded_out, 1'b0);
  endtask
  // every polarity and drive mode against idle, fault, warning and alarm levels
  task automatic t_relay;
    logic exp;
    tx(8'h05, 16'h0193, 16'hFF00, 8'h00, 1'b1);
    for (int m = 0; m < 4; m++) begin
      tx(8'h05, 16'h0192, m[1] ? 16'hFF00 : 16'h0000, 8'h00, m[1]);
      tx(8'h05, 16'h0194, m[0] ? 16'hFF00 : 16'h0000, 8'h00, m[0]);
      for (int c = 0; c < 4; c++) begin
        settle(c == 3 ? 16'h00FA : (c == 2 ? 16'h0096 : 16'h0032), c == 1);
        exp = (c == 1 || c == 3 || (m[0] && c == 2)) ^ m[1];
        chk(relay_energised_out, exp);
        chk(failsafe_out, m[1]);
      end
    end
  endtask
  task automatic t_proto;
    tx(8'h05, 16'h0190, 16'hFF00, 8'h00, 1'b1);
    tx(8'h01, 16'h0190, 16'h0000, 8'h00, 1'b1);
    tx(8'h05, 16'h0190, 16'h1234, 8'h03, 1'b0);
    tx(8'h03, 16'h0190, 16'h0000, 8'h01, 1'b0);
    tx(8'h01, 16'h0195, 16'h0000, 8'h02, 1'b0);
    tx(8'h02, 16'h0131, 16'h0000, 8'h00, 1'b0);
    tx(8'h05, 16'h0131, 16'hFF00, 8'h02, 1'b0);
    tx(8'h02, 16'h0131, 16'h0000, 8'h00, 1'b0);
    tx(8'h02, 16'h0132, 16'h0000, 8'h00, 1'b0);
    chk(sounder_on_out, 1'b1);
  endtask
  initial begin
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_age();
    t_warn();
    t_relay();
    t_proto();
    results();
  end
endmodule
